// *** rtl/scp_serial_port.v ***
// four-wire serial configuration port with its register store
`timescale 1ns/1ns
`include "scp_regs.vh"
module scp_serial_port (
	input  wire       clk_i,
	input  wire       rst_n_i,
	input  wire       cs_n_i,
	input  wire       sclk_i,
	input  wire       rw_i,
	input  wire       serial_io_line_i,
	output reg        serial_io_line_o,
	output wire       serial_io_line_oe_o,
	input  wire       mreset_n_i,
	output reg        tx_enable_o,
	output reg        rx_enable_o,
	output reg        standby_o,
	output reg        div2_en_o,
	output reg        div4_en_o,
	input  wire [6:0] cfg_raddr_i,
	output reg  [7:0] cfg_rdata_o
);

// ----------------------------------------
// pin synchronisation
// ----------------------------------------
wire [3:0] pins_s;
wire       cs_n_s;
wire       sclk_s;
wire       rw_s;
wire       sd_s;
reg        sclk_d;
wire       sclk_rise;

// all port pins cross through two flops before use
// limitation: each serial clock phase must last at least two clk_i cycles
scp_sync #(
	.W(`SCP_SYNC_W)
) u_sync (
	.clk_i   (clk_i),
	.rst_n_i (rst_n_i),
	.async_i ({cs_n_i, sclk_i, rw_i, serial_io_line_i}),
	.idle_i  (4'h8),
	.sync_o  (pins_s)
);

assign cs_n_s = pins_s[3];
assign sclk_s = pins_s[2];
assign rw_s   = pins_s[1];
assign sd_s   = pins_s[0];

always @(posedge clk_i) begin
	if (!rst_n_i) begin
		sclk_d <= 1'b0;
	end else begin
		sclk_d <= sclk_s;
	end
end

// only the rising serial clock edge is ever used
assign sclk_rise = sclk_s & ~sclk_d;

// ----------------------------------------
// register store
// ----------------------------------------
// no reset: contents survive both resets
reg [7:0] regs [0:`SCP_REG_COUNT-1];

// ----------------------------------------
// serial transfer state machine
// ----------------------------------------
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_ADDR = 4'h2;
localparam [3:0] ST_DATA = 4'h4;
localparam [3:0] ST_DONE = 4'h8;

reg [3:0]             state;
reg [3:0]             next_state;
reg [`SCP_CNT_W-1:0]  bit_cnt;
reg [7:0]             addr_sh;
reg [7:0]             data_sh;
reg [7:0]             rd_sh;
reg                   rd_xfer;
wire [`SCP_REG_IDX_W-1:0] reg_idx;
wire                  last_bit;
wire                  addr_last;
wire                  addr_phase;
wire                  bit_edge;

// address LSB is reserved, so pairs of addresses alias
assign reg_idx  = addr_sh[7:1];
assign last_bit = (bit_cnt == `SCP_XFER_BITS - 1);
assign addr_last  = (bit_cnt == `SCP_BYTE_BITS - 1);
assign addr_phase = (bit_cnt < `SCP_BYTE_BITS);
// a deselected port or a finished transfer counts no more edges
assign bit_edge   = sclk_rise & ~cs_n_s & (state != ST_DONE);

always @* begin
	next_state = state;
	case (state)
		ST_IDLE: begin
			if (sclk_rise)
				next_state = ST_ADDR;
		end
		ST_ADDR: begin
			if (sclk_rise && addr_last)
				next_state = ST_DATA;
		end
		ST_DATA: begin
			if (sclk_rise && last_bit)
				next_state = ST_DONE;
		end
		ST_DONE: begin
			next_state = ST_DONE;
		end
		default: begin
			next_state = ST_IDLE;
		end
	endcase
	// deselect wins over everything else
	// it is seen through the synchroniser, so an abort lags by three cycles
	if (cs_n_s)
		next_state = ST_IDLE;
end

always @(posedge clk_i) begin
	if (!rst_n_i) begin
		state   <= ST_IDLE;
		bit_cnt <= {`SCP_CNT_W{1'b0}};
		addr_sh <= 8'h00;
		data_sh <= 8'h00;
	end else begin
		state <= next_state;
		if (cs_n_s) begin
			bit_cnt <= {`SCP_CNT_W{1'b0}};
		end else if (bit_edge) begin
			bit_cnt <= bit_cnt + 1'b1;
			if (addr_phase) begin
				// first byte: address, MSB first
				addr_sh <= {addr_sh[6:0], sd_s};
			end else begin
				data_sh <= {data_sh[6:0], sd_s};
			end
		end
	end
end

// ----------------------------------------
// read data launch
// ----------------------------------------
// direction is fixed for the data byte at the last address edge
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		rd_xfer          <= 1'b0;
		rd_sh            <= 8'h00;
		serial_io_line_o <= 1'b0;
	end else if (cs_n_s) begin
		rd_xfer <= 1'b0;
	end else if (bit_edge && addr_last) begin
		rd_xfer <= rw_s;
		// the reserved LSB is still on the pin, so the index is already complete
		rd_sh   <= regs[addr_sh[6:0]];
	end else if (bit_edge && !addr_phase) begin
		// read data launched on the rising edge, MSB first
		serial_io_line_o <= rd_sh[7];
		rd_sh            <= {rd_sh[6:0], 1'b0};
	end
end

// driver on while selected and reading, through the data byte and until
// deselect, so the last bit still stands when the controller samples it
assign serial_io_line_oe_o = ~cs_n_s & rw_s & rd_xfer &
	((state == ST_DATA) | (state == ST_DONE));

// ----------------------------------------
// register write and internal read port
// ----------------------------------------
// the write happens after the 16th synchronised edge, all in clk_i domain
always @(posedge clk_i) begin
	if (state == ST_DATA && bit_edge && last_bit && !rd_xfer)
		regs[reg_idx] <= {data_sh[6:0], sd_s};
end

always @(posedge clk_i) begin
	if (!rst_n_i) begin
		cfg_rdata_o <= 8'h00;
	end else begin
		cfg_rdata_o <= regs[cfg_raddr_i];
	end
end

// ----------------------------------------
// master reset
// ----------------------------------------
// these depend on master reset and rst_n_i only, never on the serial port
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		tx_enable_o <= 1'b0;
		rx_enable_o <= 1'b0;
		standby_o   <= 1'b1;
	end else begin
		tx_enable_o <= mreset_n_i;
		rx_enable_o <= mreset_n_i;
		standby_o   <= ~mreset_n_i;
	end
end

// ----------------------------------------
// clock division
// ----------------------------------------
// free-running, so the transceiver rates keep their phase through standby
reg [1:0] div_cnt;

always @(posedge clk_i) begin
	if (!rst_n_i) begin
		div_cnt   <= 2'h0;
		div2_en_o <= 1'b0;
		div4_en_o <= 1'b0;
	end else begin
		div_cnt   <= div_cnt + 2'h1;
		div2_en_o <= (div_cnt[0] == `SCP_DIV2_LAST);
		div4_en_o <= (div_cnt == `SCP_DIV4_LAST);
	end
end

endmodule

// *** rtl/scp_regs.vh ***
// constants of the serial configuration port
`ifndef SCP_REGS_VH
`define SCP_REGS_VH

// ----------------------------------------
// transfer framing
// ----------------------------------------
`define SCP_BYTE_BITS    8
`define SCP_XFER_BITS    16
`define SCP_CNT_W        5
`define SCP_REG_IDX_W    7
`define SCP_REG_COUNT    128
`define SCP_SYNC_W       4

// ----------------------------------------
// master clock dividers
// ----------------------------------------
`define SCP_DIV2_LAST    2'h1
`define SCP_DIV4_LAST    2'h3

`endif

// *** rtl/scp_sync.v ***
// two-stage synchroniser for the serial port pins
`timescale 1ns/1ns
module scp_sync #(
	parameter W = 4
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire [W-1:0] async_i,
	input  wire [W-1:0] idle_i,
	output reg  [W-1:0] sync_o
);

reg [W-1:0] meta;

// first stage feeds only the second
// reset to the idle pin levels, so no false select or edge follows reset
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		meta   <= idle_i;
		sync_o <= idle_i;
	end else begin
		meta   <= async_i;
		sync_o <= meta;
	end
end

endmodule

// *** verification/scp_chk_assertions.sv ***
// assertions on the serial port pins
`timescale 1ns/1ns
module scp_chk (
	input wire clk_i,
	input wire rst_n_i,
	input wire cs_n_i,
	input wire sclk_i,
	input wire rw_i,
	input wire mreset_n_i,
	input wire serial_io_line_o,
	input wire serial_io_line_oe_o,
	input wire standby_o,
	input wire tx_enable_o,
	input wire rx_enable_o,
	input wire div2_en_o,
	input wire div4_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_wr_off; !rw_i [*4] |-> !serial_io_line_oe_o; endproperty
	a_wr_off: assert property (p_wr_off) else $error("driven in write");
	property p_cs_off; cs_n_i [*4] |-> !serial_io_line_oe_o; endproperty
	a_cs_off: assert property (p_cs_off) else $error("driven unselected");
	property p_tx; $past(rst_n_i) |-> tx_enable_o == $past(mreset_n_i); endproperty
	a_tx: assert property (p_tx) else $error("tx enable lag");
	property p_rx; rx_enable_o == tx_enable_o && standby_o != tx_enable_o; endproperty
	a_rx: assert property (p_rx) else $error("rx or standby");
	property p_iso; $past(rst_n_i) && $stable(mreset_n_i) |=> $stable(tx_enable_o); endproperty
	a_iso: assert property (p_iso) else $error("tx moved");
	property p_d2; div2_en_o |=> !div2_en_o ##1 div2_en_o; endproperty
	a_d2: assert property (p_d2) else $error("div2 period");
	property p_d4; div4_en_o |=> !div4_en_o [*3] ##1 div4_en_o; endproperty
	a_d4: assert property (p_d4) else $error("div4 period");
	// launches follow rising edges only, so a long low phase is quiet
	property p_sd; (!sclk_i && !cs_n_i) [*5] |-> $stable(serial_io_line_o); endproperty
	a_sd: assert property (p_sd) else $error("launch off edge");
	c_rd: cover property (serial_io_line_oe_o);
	c_ab: cover property ($rose(cs_n_i) && serial_io_line_oe_o);
	c_mr: cover property ($fell(mreset_n_i));
endmodule
bind scp_serial_port scp_chk u_chk (.*);

// *** verification/scp_ctl.sv ***
// controller model for the four-wire port
`timescale 1ns/1ns
module scp_ctl (
	input  wire clk_i,
	input  wire sd_i,
	input  wire oe_i,
	output reg  cs_n_o = 1,
	output reg  sclk_o = 0,
	output reg  rw_o = 0,
	output wire line_o
);
	reg drv = 0;
	reg d = 0;
	// released line shows the inverse so a stale bit cannot pass
	assign line_o = oe_i ? sd_i : drv ? d : !d;
	task hp;
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	task xfer(input r, input [7:0] a, input [7:0] w, input [4:0] n, output [7:0] q);
		integer i;
		@(posedge clk_i) #1;
		cs_n_o = 0;
		rw_o = r;
		q = 8'h00;
		for (i = 0; i < n; i = i + 1) begin
			drv = !(r && i > 7);
			d = i < 8 ? a[7-i] : w[15-i];
			hp;
			sclk_o = 1;
			hp;
			if (i > 7) q[15-i] = line_o;
			sclk_o = 0;
		end
		hp;
		cs_n_o = 1;
		drv = 0;
		hp;
	endtask
endmodule

// *** verification/tb_scp_serial_port.sv ***
// testbench of the serial configuration port
`timescale 1ns/1ns
module tb_scp_serial_port;
	reg        clk_i = 0;
	reg        rst_n_i = 0;
	reg        mreset_n_i = 1;
	reg  [6:0] cfg_raddr_i = 7'h00;
	wire       cs_n, sclk, rw, line, sd_o, sd_oe, tx_en, rx_en, stby;
	wire [7:0] rdata;
	reg  [7:0] q;
	integer    mismatches = 0;
	integer    n_tests = 0;
	integer    cyc = 0;
	integer    i;
	always #50 clk_i = !clk_i;
	scp_serial_port DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.rw_i(rw), .serial_io_line_i(line), .serial_io_line_o(sd_o),
		.serial_io_line_oe_o(sd_oe), .mreset_n_i(mreset_n_i), .tx_enable_o(tx_en),
		.rx_enable_o(rx_en), .standby_o(stby), .div2_en_o(), .div4_en_o(),
		.cfg_raddr_i(cfg_raddr_i), .cfg_rdata_o(rdata));
	scp_ctl ctl (.clk_i(clk_i), .sd_i(sd_o), .oe_i(sd_oe), .cs_n_o(cs_n), .sclk_o(sclk),
		.rw_o(rw), .line_o(line));
	task chk(input [7:0] e, input [7:0] g, input string nm);
		n_tests = n_tests + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rd_chk(input [7:0] a, input [7:0] e);
		ctl.xfer(1'b1, a, 8'h00, 5'd16, q);
		chk(e, q, "serial read");
		cfg_raddr_i = a[7:1];
		repeat (2) @(posedge clk_i);
		#1;
		chk(e, rdata, "store");
	endtask
	task t_rw;
		reg [7:0] a;
		for (i = 0; i < 5; i = i + 1) begin
			a = 8'hfe - 8'h3f * i[7:0];
			ctl.xfer(1'b0, a, ~a, 5'd16, q);
		end
		for (i = 0; i < 5; i = i + 1) begin
			a = 8'hfe - 8'h3f * i[7:0];
			rd_chk(a | 8'h01, ~a);
		end
	endtask
	task t_abort;
		ctl.xfer(1'b0, 8'h10, 8'h3c, 5'd16, q);
		ctl.xfer(1'b0, 8'h10, 8'hc3, 5'd12, q);
		ctl.xfer(1'b1, 8'h10, 8'h00, 5'd12, q);
		rd_chk(8'h10, 8'h3c);
	endtask
	task t_mreset;
		chk(8'h03, {6'h00, tx_en, rx_en}, "tx rx");
		mreset_n_i = 0;
		repeat (2) @(posedge clk_i);
		#1;
		chk(8'h01, {6'h00, tx_en, stby}, "standby");
		mreset_n_i = 1;
		rd_chk(8'h80, 8'h7f);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ceiling well above the roughly 2000 cycles the sequence needs
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			end_of_test;
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		#1;
		rst_n_i = 1;
		repeat (3) @(posedge clk_i);
		t_rw;
		t_abort;
		t_mreset;
		end_of_test;
	end
endmodule
